// ==== verilog/slot_fault_logic.sv ====
// Dual-slot fault latching, interrupt and forced-enable control
// Contract
// [R1] Slot overtemp with aux overcurrent kills slot
// [R2] Slot overtemp bypasses and aborts fault timer
// [R3] Shut slot shows fault; other slot runs
// [R4] Fault clears by toggling matching enable
// [R5] Die overtemp kills both, sets flag
// [R6] Channels resume prior state after die cools
// [R7] Interrupt on power fault, undervolt, die overtemp
// [R8] Direct mode: interrupt follows live fault
// [R9] Host clears faults by dropping enable pins
// [R10] Mask bit disables interrupt, resets clear; the code applies the mask in bus mode only
// [R11] Status: summary D7, aux D4, 12V D2, 3V3 D0
// [R12] Bus mode: clear fault via control bits
// [R13] Source bits sticky, write one clears
// [R14] Summary bit read only, auto clears
// [R15] Common status: undervolt D2, overtemp D1
// [R16] Forced enable turns outputs on regardless
// [R17] Aux undervolt still cuts forced aux
// [R18] Forced outputs survive slot overtemp only
// [R19] Forced mode holds fault, good pins false
// [R20] Inhibit bit ignores forced enable input
// [R21] Control write switches to bus mode for good
// [R22] Bus mode: summary bit reads inactive
// [R23] Interrupt from latched flags unless masked
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module slot_fault_logic (
    input  wire logic       pclk,
    input  wire logic       presetn,
    hp_fault_if.dev         link,
    input  wire logic [1:0] slot_overtemp,     // Slot reached its overtemp level
    input  wire logic       die_overtemp,      // Die reached second overtemp level
    input  wire logic [1:0] aux_overcurrent,   // Aux overcurrent present
    input  wire logic [1:0] rail12_fault_evt,  // 12 V fault timer expired
    input  wire logic [1:0] rail33_fault_evt,  // 3.3 V fault timer expired
    input  wire logic [1:0] aux_fault_evt,     // Aux fault timer expired
    input  wire logic [1:0] aux_undervolt,     // Aux supply input undervoltage
    input  wire logic       main_undervolt,    // Main supply undervoltage
    input  wire logic [1:0] main_pg_in,        // Main rails above good level
    input  wire logic [1:0] aux_pg_in,         // Aux output above good level
    output logic      [1:0] main_power_on,     // Main switch gate enables
    output logic      [1:0] aux_power_on,      // Aux switch enables
    output logic      [1:0] fault_timer_abort  // Cancels a running fault timer
);

    // Whole state of the block
    typedef struct packed {
        logic            sbus;     // Bus control mode, sticky until reset
        logic [1:0][2:0] ctrl;     // Writable control bits per slot
        logic [1:0]      fm;       // Live main fault latch
        logic [1:0]      fa;       // Live aux fault latch
        logic [1:0][2:0] src;      // Sticky sources: aux, 12 V, 3.3 V
        logic            uv;       // Main undervolt flag
        logic            ot;       // Die overtemp flag
        logic            mask;     // Interrupt mask
        logic            ack;
        logic [7:0]      rdata;
        logic [1:0]      main_on;
        logic [1:0]      aux_on;
        logic [1:0]      abort;
        logic [1:0]      flt;
        logic [1:0]      pg;
        logic            irq_n;
    } dev_state_t;

    dev_state_t s;       // Registered state
    dev_state_t next_s;  // Next state

    // Next-state logic for both slots and the common flags
    always_comb begin
        logic       wr;          // Write request this cycle
        logic       forced;      // Forced enable in effect
        logic       ot_trip;     // Slot thermal shutdown condition
        logic       main_req;    // Main enable from pin or bit
        logic       aux_req;     // Aux enable from pin or bit
        logic       any_live;    // Any live fault for direct interrupt
        logic       any_flag;    // Any latched flag for bus interrupt
        logic [2:0] src_set;     // Source bits set this cycle
        next_s   = s;
        wr       = link.reg_sel & link.reg_write;
        forced   = 1'b0;
        ot_trip  = 1'b0;
        main_req = 1'b0;
        aux_req  = 1'b0;
        any_live = 1'b0;
        any_flag = 1'b0;
        src_set  = 3'h0;
        next_s.ack = link.reg_sel;

        // Common flags: set wins over a write-one clear
        if (wr && link.reg_addr == hp_fault_pkg::ADDR_COMMON) begin
            if (link.reg_wdata[hp_fault_pkg::COM_UV])
                next_s.uv = 1'b0;                                  // [R15]
            if (link.reg_wdata[hp_fault_pkg::COM_OT])
                next_s.ot = 1'b0;                                  // [R15]
            next_s.mask = link.reg_wdata[hp_fault_pkg::COM_MASK];  // [R10]
        end
        if (main_undervolt)
            next_s.uv = 1'b1;                                      // [R15]
        if (die_overtemp)
            next_s.ot = 1'b1;                                      // [R5]

        // Any control write leaves direct mode until reset
        if (wr && (link.reg_addr == hp_fault_pkg::ADDR_CTRL_A ||
                   link.reg_addr == hp_fault_pkg::ADDR_CTRL_B))
            next_s.sbus = 1'b1;                                    // [R21]

        // Per-slot protection
        for (int i = 0; i < 2; i++) begin
            if (wr && link.reg_addr == 3'(hp_fault_pkg::ADDR_CTRL_A + 3'(i)))
                next_s.ctrl[i] = link.reg_wdata[2:0];
            // Inhibit bit gates the forced pin
            forced = !link.forced_enable_n[i]
                     && !s.ctrl[i][hp_fault_pkg::CTRL_INHIBIT];    // [R20]
            ot_trip = slot_overtemp[i] & aux_overcurrent[i];       // [R1]
            // Enable source depends on control mode
            if (s.sbus) begin
                main_req = s.ctrl[i][hp_fault_pkg::CTRL_MAIN_EN];  // [R12]
                aux_req  = s.ctrl[i][hp_fault_pkg::CTRL_AUX_EN];   // [R12]
            end else begin
                main_req = link.main_power_enable_in[i];           // [R9]
                aux_req  = link.aux_power_enable_in[i];            // [R9]
            end
            // Live latches clear with their enable; a new event wins
            if (!main_req)
                next_s.fm[i] = 1'b0;                               // [R4]
            if (!aux_req)
                next_s.fa[i] = 1'b0;                               // [R4]
            if (rail12_fault_evt[i] || rail33_fault_evt[i] || ot_trip)
                next_s.fm[i] = 1'b1;                               // [R1]
            if (aux_fault_evt[i] || aux_undervolt[i] || ot_trip)
                next_s.fa[i] = 1'b1;                               // [R1]
            // Sticky sources: write one clears, set wins
            src_set = {aux_fault_evt[i] | aux_undervolt[i] | ot_trip,
                       rail12_fault_evt[i] | ot_trip,
                       rail33_fault_evt[i]};
            if (wr && link.reg_addr == 3'(hp_fault_pkg::ADDR_STAT_A + 3'(i)))
                next_s.src[i] = s.src[i] & ~{link.reg_wdata[hp_fault_pkg::STAT_AUX],
                                             link.reg_wdata[hp_fault_pkg::STAT_RAIL12],
                                             link.reg_wdata[hp_fault_pkg::STAT_RAIL33]};
            next_s.src[i] = next_s.src[i] | src_set;               // [R13]
            // Thermal trip aborts this slot's timer only
            next_s.abort[i] = ot_trip;                             // [R2]
            // Die overtemp overrides everything; enables kept for resume
            if (die_overtemp) begin
                next_s.main_on[i] = 1'b0;                          // [R5] [R18]
                next_s.aux_on[i]  = 1'b0;                          // [R5] [R18]
            end else if (forced) begin
                next_s.main_on[i] = 1'b1;                          // [R16] [R18]
                next_s.aux_on[i]  = !aux_undervolt[i];             // [R17]
            end else begin
                next_s.main_on[i] = main_req && !next_s.fm[i];     // [R1] [R6]
                next_s.aux_on[i]  = aux_req && !next_s.fa[i]
                                    && !aux_undervolt[i];          // [R6]
            end
            // Pins read false while forced
            next_s.flt[i] = !forced && (next_s.fm[i] || next_s.fa[i]);   // [R3] [R19]
            next_s.pg[i]  = !forced && main_pg_in[i] && next_s.main_on[i]; // [R19]
            any_live = any_live | s.fm[i] | s.fa[i];
            any_flag = any_flag | (|s.src[i]) | s.fm[i] | s.fa[i];
        end

        // Interrupt: live faults in direct mode, masked flags on bus
        if (s.sbus)
            next_s.irq_n = !((any_flag || s.uv || s.ot) && !s.mask);     // [R10] [R23]
        else
            next_s.irq_n = !(any_live || main_undervolt || die_overtemp); // [R7] [R8]

        // Read mux, answered the cycle after the request
        unique case (link.reg_addr)
            hp_fault_pkg::ADDR_CTRL_A, hp_fault_pkg::ADDR_CTRL_B: begin
                next_s.rdata = {aux_pg_in[link.reg_addr[0]] & s.aux_on[link.reg_addr[0]],
                                main_pg_in[link.reg_addr[0]] & s.main_on[link.reg_addr[0]],
                                3'h0, s.ctrl[link.reg_addr[0]]};
            end
            hp_fault_pkg::ADDR_STAT_A, hp_fault_pkg::ADDR_STAT_B: begin
                next_s.rdata = {!s.sbus && (|s.src[link.reg_addr[0]]), // [R14] [R22]
                                2'h0, s.src[link.reg_addr[0]][2], 1'b0,
                                s.src[link.reg_addr[0]][1], 1'b0,
                                s.src[link.reg_addr[0]][0]};       // [R11]
            end
            hp_fault_pkg::ADDR_COMMON: begin
                next_s.rdata = {5'h00, s.uv, s.ot, s.mask};        // [R15]
            end
            default: begin
                next_s.rdata = 8'h00;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state
    assign link.reg_ack             = s.ack;
    assign link.reg_rdata           = s.rdata;
    assign link.irq_n               = s.irq_n;
    assign link.slot_fault_flag     = s.flt;
    assign link.slot_power_good_out = s.pg;
    assign main_power_on            = s.main_on;
    assign aux_power_on             = s.aux_on;
    assign fault_timer_abort        = s.abort;

endmodule : slot_fault_logic

// ==== verilog/hp_fault_pkg.sv ====
// Shared constants for the dual-slot fault and interrupt logic and its host
package hp_fault_pkg;
    // Device register indices on the register link
    localparam logic [2:0] ADDR_CTRL_A  = 3'h2;
    localparam logic [2:0] ADDR_CTRL_B  = 3'h3;
    localparam logic [2:0] ADDR_STAT_A  = 3'h4;
    localparam logic [2:0] ADDR_STAT_B  = 3'h5;
    localparam logic [2:0] ADDR_COMMON  = 3'h6;
    // Slot control register fields
    localparam int CTRL_AUX_EN     = 0;  // aux enable bit
    localparam int CTRL_MAIN_EN    = 1;  // main_enable_bit
    localparam int CTRL_INHIBIT    = 2;  // forced_enable_inhibit_bit
    localparam int CTRL_MAIN_PG    = 6;  // Main power good, read only
    localparam int CTRL_AUX_PG     = 7;  // Aux power good, read only
    // Slot status register fields
    localparam int STAT_RAIL33     = 0;  // rail33_fault_bit
    localparam int STAT_RAIL12     = 2;  // rail12_fault_bit
    localparam int STAT_AUX        = 4;  // aux_fault_bit
    localparam int STAT_SUMMARY    = 7;  // Summary fault flag
    // Common status register fields
    localparam int COM_MASK        = 0;  // irq_mask_bit
    localparam int COM_OT          = 1;  // die_overtemp_flag
    localparam int COM_UV          = 2;  // main_undervolt_flag
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] FORCE_N_RESET = 2'h3;
    // Host APB register byte offsets
    localparam logic [7:0] APB_CMD     = 8'h00;
    localparam logic [7:0] APB_STATUS  = 8'h04;
    localparam logic [7:0] APB_PINS    = 8'h08;
    // Host command word fields
    localparam int CMD_ADDR_LSB    = 8;
    localparam int CMD_WRITE       = 16;
    // Host status word fields
    localparam int HST_BUSY        = 8;
    localparam int HST_IRQ         = 9;
    localparam int HST_FAULT_LSB   = 10;
    localparam int HST_PG_LSB      = 12;
    // Host pin word fields
    localparam int PIN_MAIN_LSB    = 0;
    localparam int PIN_AUX_LSB     = 2;
    localparam int PIN_FORCE_LSB   = 4;
endpackage : hp_fault_pkg

// ==== verilog/hp_fault_if.sv ====
// Link between the fault logic device and its host controller
`timescale 1ns/100ps
interface hp_fault_if;
    logic       reg_sel;              // One-cycle register request
    logic       reg_write;            // Request is a write
    logic [2:0] reg_addr;             // Register index
    logic [7:0] reg_wdata;            // Write data
    logic [7:0] reg_rdata;            // Read data, valid with reg_ack
    logic       reg_ack;              // One-cycle answer
    logic [1:0] main_power_enable_in; // Direct-mode main enables
    logic [1:0] aux_power_enable_in;  // Direct-mode aux enables
    logic [1:0] forced_enable_n;      // Forced-on inputs, active low
    logic       irq_n;                // Interrupt, active low
    logic [1:0] slot_fault_flag;      // Slot fault pins
    logic [1:0] slot_power_good_out;  // Slot power good pins

    modport dev (
        input  reg_sel, reg_write, reg_addr, reg_wdata,
        input  main_power_enable_in, aux_power_enable_in, forced_enable_n,
        output reg_rdata, reg_ack, irq_n, slot_fault_flag, slot_power_good_out
    );
    modport host (
        output reg_sel, reg_write, reg_addr, reg_wdata,
        output main_power_enable_in, aux_power_enable_in, forced_enable_n,
        input  reg_rdata, reg_ack, irq_n, slot_fault_flag, slot_power_good_out
    );
endinterface : hp_fault_if

// ==== verilog/slot_fault_host.sv ====
// Host controller end: APB slave driving the fault logic link
`timescale 1ns/100ps
module slot_fault_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    hp_fault_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // Link sequencer states
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,  // Ready for a command
        H_SEL  = 2'b01,  // Request strobe out
        H_WAIT = 2'b10   // Waiting for the answer
    } host_fsm_t;

    // Whole state of the host
    typedef struct packed {
        host_fsm_t  fsm;
        logic       write;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [5:0] pins;    // Forced, aux, main pin levels
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
    } host_state_t;

    host_state_t s;       // Registered state
    host_state_t next_s;  // Next state

    // APB decode and link sequencing
    always_comb begin
        logic busy;    // A link transfer is in flight
        logic access;  // APB access phase awaiting answer
        next_s = s;
        busy   = s.fsm != H_IDLE;
        access = psel && penable && !s.pready;
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;

        // Link transfer sequencing
        unique case (s.fsm)
            H_IDLE: begin
                next_s.fsm = H_IDLE;
            end
            H_SEL: begin
                next_s.fsm = H_WAIT;
            end
            H_WAIT: begin
                if (link.reg_ack) begin
                    next_s.rdata = link.reg_rdata;
                    next_s.fsm   = H_IDLE;
                end
            end
            default: begin
                next_s.fsm = H_IDLE;
            end
        endcase

        // A command write stalls while a transfer is in flight
        if (access && !(pwrite && paddr == hp_fault_pkg::APB_CMD && busy)) begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0000_0000;
            unique case (paddr)
                hp_fault_pkg::APB_CMD: begin
                    if (pwrite) begin
                        next_s.write = pwdata[hp_fault_pkg::CMD_WRITE];
                        next_s.addr  = pwdata[hp_fault_pkg::CMD_ADDR_LSB +: 3];
                        next_s.wdata = pwdata[7:0];
                        next_s.fsm   = H_SEL;
                    end
                end
                hp_fault_pkg::APB_STATUS: begin
                    next_s.prdata[7:0] = s.rdata;
                    next_s.prdata[hp_fault_pkg::HST_BUSY] = busy;
                    next_s.prdata[hp_fault_pkg::HST_IRQ]  = !link.irq_n;
                    next_s.prdata[hp_fault_pkg::HST_FAULT_LSB +: 2] = link.slot_fault_flag;
                    next_s.prdata[hp_fault_pkg::HST_PG_LSB +: 2] = link.slot_power_good_out;
                end
                hp_fault_pkg::APB_PINS: begin
                    if (pwrite)
                        next_s.pins = pwdata[5:0];         // [R9]
                    next_s.prdata[5:0] = s.pins;
                end
                default: begin
                    next_s.pslverr = 1'b1;                 // Unmapped address
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s      <= '0;
            s.fsm  <= H_IDLE;
            s.pins <= {hp_fault_pkg::FORCE_N_RESET, 4'h0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state
    assign link.reg_sel   = s.fsm == H_SEL;
    assign link.reg_write = s.write;
    assign link.reg_addr  = s.addr;
    assign link.reg_wdata = s.wdata;
    assign link.main_power_enable_in = s.pins[hp_fault_pkg::PIN_MAIN_LSB +: 2];
    assign link.aux_power_enable_in  = s.pins[hp_fault_pkg::PIN_AUX_LSB +: 2];
    assign link.forced_enable_n      = s.pins[hp_fault_pkg::PIN_FORCE_LSB +: 2];
    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;

endmodule : slot_fault_host

// ==== test/dual_slot_fault_assertions.sv ====
// Concurrent checks on the link between the host end and the fault logic
`timescale 1ns/100ps
module dual_slot_fault_assertions (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       reg_sel,
    input wire logic       reg_write,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack,
    input wire logic [1:0] forced_enable_n,
    input wire logic       irq_n,
    input wire logic [1:0] slot_fault_flag,
    input wire logic [1:0] slot_power_good_out
);
    logic       bus_mode; // Set by any control write, never cleared
    logic [2:0] ctrl_a;   // Shadow of slot A writable control bits
    logic       mask;     // Shadow of the interrupt mask
    wire        wr = reg_sel && reg_write;   // Write taken at this edge
    wire        rd = reg_sel && !reg_write;  // Read taken at this edge
    // Shadows follow taken writes only, so a lost write shows up later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_mode <= 1'b0;
            ctrl_a   <= 3'h0;
            mask     <= 1'b0;
        end else if (wr) begin
            bus_mode <= bus_mode | (reg_addr[2:1] == 2'h1);
            if (reg_addr == hp_fault_pkg::ADDR_CTRL_A) ctrl_a <= reg_wdata[2:0];
            if (reg_addr == hp_fault_pkg::ADDR_COMMON) mask <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A read of one register index
    sequence read_of(a);
        rd && reg_addr == a;
    endsequence
    // Two cycles in bus mode with the mask set
    sequence masked_run;
        (bus_mode && mask) [*2];
    endsequence
    chk_ack_follows: assert property (reg_sel |=> reg_ack)
        else $error("no answer one cycle after request");
    chk_ack_caused: assert property (reg_ack |-> $past(reg_sel))
        else $error("answer without request");
    chk_unmapped_zero: assert property (read_of(3'h0) or read_of(3'h1) or read_of(3'h7)
        |=> reg_rdata == 8'h00) else $error("unmapped index read not zero");
    chk_ctrl_reserved: assert property (rd && reg_addr[2:1] == 2'h1 |=> reg_rdata[5:3] == 3'h0)
        else $error("control reserved bits not zero");
    chk_ctrl_readback: assert property (read_of(hp_fault_pkg::ADDR_CTRL_A)
        |=> reg_rdata[2:0] == $past(ctrl_a)) else $error("control bits lost");
    chk_summary_idle: assert property (bus_mode && rd && reg_addr[2:1] == 2'h2
        |=> !reg_rdata[7]) else $error("summary bit set in bus mode");
    chk_irq_masked: assert property (masked_run |-> irq_n)
        else $error("interrupt while masked");
    chk_forced_quiet: assert property ((!forced_enable_n[0] && !ctrl_a[2]) [*3]
        |-> !slot_fault_flag[0] && !slot_power_good_out[0]) else $error("forced pins not false");
endmodule : dual_slot_fault_assertions

// ==== test/test_dual_slot_fault_interrupt_logic.sv ====
// Testbench joining both ends over the link and driving the host over APB
`timescale 1ns/100ps
module test_dual_slot_fault_interrupt_logic;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr; // APB side
    logic [7:0]  paddr;                  // APB address
    logic [31:0] pwdata, prdata, r;      // APB data and last read word
    logic [1:0]  sot, aoc, auv, mpg, afe, r33; // Trips, aux oc, aux uv, pg, aux and 3V3 faults
    logic        dot, muv;               // Die trip, main undervolt
    logic [1:0]  mon, aon, abort;        // Switch outputs and timer abort
    int          fails, checks_done, cyc; // Counters
    hp_fault_if link ();
    slot_fault_logic slot_fault_logic_i (.pclk(pclk), .presetn(presetn), .link(link),
        .slot_overtemp(sot), .die_overtemp(dot), .aux_overcurrent(aoc),
        .rail12_fault_evt(2'h0), .rail33_fault_evt(r33), .aux_fault_evt(afe),
        .aux_undervolt(auv), .main_undervolt(muv), .main_pg_in(mpg), .aux_pg_in(2'h3),
        .main_power_on(mon), .aux_power_on(aon), .fault_timer_abort(abort));
    slot_fault_host slot_fault_host_i (.pclk(pclk), .presetn(presetn), .link(link),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dual_slot_fault_assertions dual_slot_fault_assertions_i (.pclk(pclk), .presetn(presetn),
        .reg_sel(link.reg_sel), .reg_write(link.reg_write), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
        .forced_enable_n(link.forced_enable_n), .irq_n(link.irq_n),
        .slot_fault_flag(link.slot_fault_flag), .slot_power_good_out(link.slot_power_good_out));
    // Free-running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard: a run this long means a wait never ended
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; an idle edge first keeps back-to-back calls race free
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Device register access through the command word, then poll until idle
    task automatic dev(input logic w, input logic [2:0] i, input logic [7:0] d);
        apb(1'b1, hp_fault_pkg::APB_CMD, {15'h0, w, 5'h0, i, d});
        do apb(1'b0, hp_fault_pkg::APB_STATUS, 32'h0); while (r[8] !== 1'b0);
    endtask : dev
    task automatic rd(input logic [2:0] i, input logic [7:0] exp);
        dev(1'b0, i, 8'h00);
        chk({24'h0, r[7:0]}, {24'h0, exp});
    endtask : rd
    // Pin summary {pg, fault, irq}, only bits under m compared
    task automatic stat(input logic [4:0] exp, input logic [4:0] m);
        apb(1'b0, hp_fault_pkg::APB_STATUS, 32'h0);
        chk({27'h0, r[13:9] & m}, {27'h0, exp & m});
    endtask : stat
    task automatic pins(input logic [5:0] p);
        apb(1'b1, hp_fault_pkg::APB_PINS, {26'h0, p});
        repeat (4) @(posedge pclk);
    endtask : pins
    task automatic pw(input logic [3:0] exp);
        repeat (4) @(posedge pclk);
        chk({28'h0, aon, mon}, {28'h0, exp});
    endtask : pw
    // Defaults after reset, unmapped places
    task automatic t_reset();
        rd(hp_fault_pkg::ADDR_COMMON, 8'h00);
        rd(hp_fault_pkg::ADDR_STAT_A, 8'h00);
        rd(3'h0, 8'h00);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        stat(5'h00, 5'h1F);
    endtask : t_reset
    // Slot A thermal trip in direct mode, then clearing by pins and by write one
    task automatic t_slot_trip();
        pins(6'h3F);
        pw(4'hF);
        sot <= 2'h1;
        aoc <= 2'h1;
        pw(4'hA);
        chk({30'h0, abort}, 32'h1);
        stat(5'b10011, 5'h1F);
        rd(hp_fault_pkg::ADDR_STAT_A, 8'h94);
        sot <= 2'h0;
        aoc <= 2'h0;
        pins(6'h3A);
        stat(5'b10000, 5'h1F);
        rd(hp_fault_pkg::ADDR_STAT_A, 8'h94);
        dev(1'b1, hp_fault_pkg::ADDR_STAT_A, 8'h14);
        rd(hp_fault_pkg::ADDR_STAT_A, 8'h00);
        pins(6'h3F);
        pw(4'hF);
    endtask : t_slot_trip
    // Die trip, resume, undervolt flag, write-one clears
    task automatic t_die();
        dot <= 1'b1;
        pw(4'h0);
        stat(5'b00001, 5'h01);
        rd(hp_fault_pkg::ADDR_COMMON, 8'h02);
        dot <= 1'b0;
        pw(4'hF);
        muv <= 1'b1;
        @(posedge pclk);
        muv <= 1'b0;
        rd(hp_fault_pkg::ADDR_COMMON, 8'h06);
        dev(1'b1, hp_fault_pkg::ADDR_COMMON, 8'h06);
        rd(hp_fault_pkg::ADDR_COMMON, 8'h00);
    endtask : t_die
    // Forced enable on slot A against faults, then inhibited from the bus
    task automatic t_forced();
        pins(6'h20);
        sot <= 2'h1;
        aoc <= 2'h1;
        pw(4'h5);
        stat(5'b00000, 5'b11110);
        sot <= 2'h0;
        aoc <= 2'h0;
        auv <= 2'h1;
        pw(4'h1);
        auv <= 2'h0;
        dot <= 1'b1;
        pw(4'h0);
        dot <= 1'b0;
        dev(1'b1, hp_fault_pkg::ADDR_CTRL_A, 8'h04);
        pw(4'h0);
        rd(hp_fault_pkg::ADDR_CTRL_A, 8'h04);
    endtask : t_forced
    // Bus mode: pins ignored, fault cleared by control bits, mask
    task automatic t_bus();
        pins(6'h3F);
        pw(4'h0);
        dev(1'b1, hp_fault_pkg::ADDR_CTRL_A, 8'h07);
        dev(1'b1, hp_fault_pkg::ADDR_CTRL_B, 8'h03);
        pw(4'hF);
        afe <= 2'h1;
        r33 <= 2'h1;
        @(posedge pclk);
        afe <= 2'h0;
        r33 <= 2'h0;
        pw(4'hA);
        rd(hp_fault_pkg::ADDR_STAT_A, 8'h15);
        stat(5'h01, 5'h01);
        dev(1'b1, hp_fault_pkg::ADDR_COMMON, 8'h01);
        stat(5'h00, 5'h01);
        dev(1'b1, hp_fault_pkg::ADDR_COMMON, 8'h06);
        stat(5'h01, 5'h01);
        dev(1'b1, hp_fault_pkg::ADDR_CTRL_A, 8'h04);
        dev(1'b1, hp_fault_pkg::ADDR_CTRL_A, 8'h07);
        pw(4'hF);
        dev(1'b1, hp_fault_pkg::ADDR_STAT_A, 8'h15);
        rd(hp_fault_pkg::ADDR_STAT_A, 8'h00);
        stat(5'h00, 5'h01);
    endtask : t_bus
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    // Reset for 20 cycles, then the scenarios in order
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, dot, muv} = '0;
        {sot, aoc, auv, afe, r33, fails, checks_done} = '0;
        mpg = 2'h3;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_slot_trip();
        t_die();
        t_forced();
        t_bus();
        stop_test();
    end
endmodule : test_dual_slot_fault_interrupt_logic
